// ---- design/error_event_queue.sv ----
`timescale 1ns/10ps
module error_event_queue (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Queue control
    input wire logic errPush,
    input wire error_event_queue_pkg::code_t errCode,
    input wire error_event_queue_pkg::len_t errLen,
    input wire logic errorRead,
    input wire logic clearStatus,
    input wire logic resetCmd,
    // Parser checks
    input wire logic headerDone,
    input wire logic [7:0] headerLen,
    input wire logic numDone,
    input wire logic [15:0] expMag,
    input wire logic [9:0] mantDigits,
    input wire logic [9:0] mantLeadZeros,
    input wire logic strDone,
    input wire logic [7:0] strLen,
    input wire logic blockData,
    input wire logic exprData,
    input wire logic rangeErr,
    // Trigger
    input wire logic busTrigger,
    input wire logic trigSourceBus,
    input wire logic trigInitiated,
    // Response buffer
    input wire logic respCmd,
    input wire logic talkAddressed,
    input wire logic respOverflow,
    input wire logic inputFull,
    input wire logic idnNotLast,
    // Self-test
    input wire logic selfTestFail,
    input wire error_event_queue_pkg::code_t selfTestCode,
    // Read answer
    output logic readValid,
    output error_event_queue_pkg::code_t readCode,
    output error_event_queue_pkg::len_t readLen,
    // Indicators
    output logic errorLamp,
    output logic beep,
    output logic responsePending,
    output logic cmdRejected
);
    import error_event_queue_pkg::*;

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    code_t codeMem [QUEUE_DEPTH];
    len_t lenMem [QUEUE_DEPTH];
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] count_q;
    logic [PTR_W-1:0] count_d;
    logic ovf_q;
    logic pend_q;
    logic stPend_q;
    code_t stCode_q;
    logic readValid_q;
    code_t readCode_q;
    len_t readLen_q;
    logic lamp_q;
    logic beep_q;
    logic reject_q;

    logic hit;
    code_t hitCode;
    len_t hitLen;
    logic hitReject;
    logic full;
    logic doPop;
    logic pushOk;
    logic pushOvf;
    logic respInterrupted;
    logic respUnterminated;
    logic deadlock;

    // Pointers wrap at the last slot rather than at a power of two.
    function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
        nextPtr = (p == PTR_LAST) ? PTR_RESET : p + 5'h01;
    endfunction

    function automatic logic [PTR_W-1:0] prevPtr(input logic [PTR_W-1:0] p);
        prevPtr = (p == PTR_RESET) ? PTR_LAST : p - 5'h01;
    endfunction

    // ------------------------------------------------------------------
    // Error sources
    // ------------------------------------------------------------------

    // Interrupted and unterminated replies are judged against the pending reply flag; deadlock is not.
    assign respInterrupted = respCmd && pend_q;
    assign respUnterminated = talkAddressed && !pend_q;
    assign deadlock = respOverflow && inputFull;

    error_source_select sel (
        .stPending(stPend_q),
        .stCode(stCode_q),
        .selfTestFail(selfTestFail),
        .respInterrupted(respInterrupted),
        .respUnterminated(respUnterminated),
        .deadlock(deadlock),
        .idnNotLast(idnNotLast),
        .headerDone(headerDone),
        .headerLen(headerLen),
        .numDone(numDone),
        .expMag(expMag),
        .mantDigits(mantDigits),
        .mantLeadZeros(mantLeadZeros),
        .strDone(strDone),
        .strLen(strLen),
        .blockData(blockData),
        .exprData(exprData),
        .rangeErr(rangeErr),
        .busTrigger(busTrigger),
        .trigSourceBus(trigSourceBus),
        .trigInitiated(trigInitiated),
        .errPush(errPush),
        .errCode(errCode),
        .errLen(errLen),
        .hit(hit),
        .code(hitCode),
        .len(hitLen),
        .reject(hitReject)
    );

    // The specific self-test code follows the general one a cycle later.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stPend_q <= 1'b0;
            stCode_q <= CODE_NO_ERROR;
        end else begin
            stPend_q <= selfTestFail && !stPend_q;
            stCode_q <= selfTestCode;
        end
    end

    // Reply flag; a second query never overwrites the earlier reply.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pend_q <= 1'b0;
        end else if (resetCmd) begin
            pend_q <= 1'b0;
        end else if (deadlock) begin
            pend_q <= 1'b0;
        end else if (talkAddressed && pend_q) begin
            pend_q <= 1'b0;
        end else if (respCmd) begin
            pend_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Queue control
    // ------------------------------------------------------------------

    // The pop is taken before the push, so a full queue can still store.
    assign full = (count_q == COUNT_FULL);
    assign doPop = errorRead && (count_q != COUNT_RESET);
    assign pushOk = hit && (clearStatus || !full || doPop);
    assign pushOvf = hit && full && !doPop && !ovf_q;

    always_comb begin
        if (clearStatus) begin
            count_d = pushOk ? 5'h01 : COUNT_RESET;
        end else begin
            count_d = count_q + {4'h0, pushOk} - {4'h0, doPop};
        end
    end

    // Clear status wins over stored entries but not over a new error.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdPtr_q <= PTR_RESET;
            wrPtr_q <= PTR_RESET;
            count_q <= COUNT_RESET;
        end else if (clearStatus) begin
            rdPtr_q <= PTR_RESET;
            wrPtr_q <= pushOk ? 5'h01 : PTR_RESET;
            count_q <= count_d;
        end else begin
            if (doPop) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
            if (pushOk) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            count_q <= count_d;
        end
    end

    // Once overflow is marked, further errors are dropped until a pop or a clear status.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ovf_q <= 1'b0;
        end else if (clearStatus || doPop) begin
            ovf_q <= 1'b0;
        end else if (pushOvf) begin
            ovf_q <= 1'b1;
        end
    end

    // Entry storage carries no reset; only valid slots are ever read.
    always_ff @(posedge clock) begin
        if (pushOk) begin
            codeMem[clearStatus ? PTR_RESET : wrPtr_q] <= hitCode;
            lenMem[clearStatus ? PTR_RESET : wrPtr_q] <= hitLen;
        end else if (pushOvf && !clearStatus) begin
            codeMem[prevPtr(wrPtr_q)] <= CODE_QUEUE_OVERFLOW;
            lenMem[prevPtr(wrPtr_q)] <= textLen(CODE_QUEUE_OVERFLOW);
        end
    end

    // ------------------------------------------------------------------
    // Answers and indicators
    // ------------------------------------------------------------------

    // A read of the empty queue answers with the no-error entry.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            readValid_q <= 1'b0;
            readCode_q <= CODE_NO_ERROR;
            readLen_q <= 7'h00;
        end else begin
            readValid_q <= errorRead;
            if (doPop) begin
                readCode_q <= codeMem[rdPtr_q];
                readLen_q <= lenMem[rdPtr_q];
            end else if (errorRead) begin
                readCode_q <= CODE_NO_ERROR;
                readLen_q <= textLen(CODE_NO_ERROR);
            end
        end
    end

    // Lamp follows the next count so it drops with the last pop.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lamp_q <= 1'b0;
        end else begin
            lamp_q <= (count_d != COUNT_RESET);
        end
    end

    // Dropped errors still beep; they were generated all the same.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            beep_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            beep_q <= hit;
            reject_q <= hit && hitReject;
        end
    end

    assign readValid = readValid_q;
    assign readCode = readCode_q;
    assign readLen = readLen_q;
    assign errorLamp = lamp_q;
    assign beep = beep_q;
    assign responsePending = pend_q;
    assign cmdRejected = reject_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence storeIntoEmpty;
        hit && count_q == COUNT_RESET && !clearStatus && !errorRead;
    endsequence

    sequence popNext;
        errorRead && !clearStatus;
    endsequence

    sequence selfTestPair;
        (hit && hitCode == CODE_SELF_TEST) ##1 (hit && stPend_q);
    endsequence

    AST_DEPTH: assert property (
        count_q <= COUNT_FULL
    ) else $error("Queue holds more than twenty entries.");

    AST_BEEP: assert property (
        hit |=> beep ##1 (beep == $past(hit))
    ) else $error("Beep does not follow the generated error.");

    AST_FIFO_ORDER: assert property (
        storeIntoEmpty ##1 popNext |=> readCode == $past(hitCode, 2)
    ) else $error("First entry read is not the first stored.");

    AST_LAMP: assert property (
        errorLamp == (count_q != COUNT_RESET)
    ) else $error("Error lamp disagrees with queue contents.");

    AST_OVERFLOW: assert property (
        pushOvf && !clearStatus |=>
            codeMem[prevPtr(wrPtr_q)] == CODE_QUEUE_OVERFLOW && full
    ) else $error("Overflow code missing in newest entry.");

    AST_DROP: assert property (
        ovf_q && hit && !errorRead && !clearStatus |=>
            $stable(wrPtr_q) && $stable(count_q)
    ) else $error("Error stored while overflow is marked.");

    AST_EMPTY_READ: assert property (
        errorRead && count_q == COUNT_RESET |=>
            readValid && readCode == CODE_NO_ERROR && readLen == 7'h08
    ) else $error("Empty read did not return the no-error entry.");

    AST_CLEAR: assert property (
        clearStatus && !hit |=> count_q == COUNT_RESET && !errorLamp
    ) else $error("Clear status left entries in the queue.");

    AST_RESET_KEEPS: assert property (
        resetCmd && !clearStatus && !hit && !errorRead |=> $stable(count_q)
    ) else $error("Reset command changed the queue.");

    AST_POP_ONE: assert property (
        doPop && !hit && !clearStatus |=> count_q == $past(count_q) - 5'h01
    ) else $error("Query did not remove exactly one entry.");

    AST_FULL_READ_FIRST: assert property (
        full && hit && errorRead && !clearStatus |=> full && !ovf_q
    ) else $error("Same-cycle push on full queue was not stored.");

    AST_TEXT_LEN: assert property (
        readValid |-> readLen <= TEXT_MAX
    ) else $error("Description longer than the text limit.");

    AST_SELF_TEST: assert property (
        selfTestFail && !stPend_q |-> selfTestPair
    ) else $error("Self-test failure not logged as a pair.");

    AST_INTERRUPTED: assert property (
        respCmd && pend_q && !deadlock && !stPend_q && !selfTestFail
            && !resetCmd && !talkAddressed |->
            hitCode == CODE_INTERRUPTED ##1 responsePending
    ) else $error("Interrupted query not logged or reply lost.");

    AST_REPLY_RESET: assert property (
        resetCmd |=> !responsePending
    ) else $error("Reset command left a reply pending.");

    AST_HEADER: assert property (
        headerDone && headerLen > HEADER_MAX && !stPend_q && !selfTestFail
            && !deadlock && !respInterrupted && !respUnterminated
            && !idnNotLast |-> hit && hitCode == CODE_HEADER_LONG
    ) else $error("Long header not logged.");
endmodule

// ---- design/error_event_queue_pkg.sv ----
package error_event_queue_pkg;

    // ------------------------------------------------------------------
    // Sizes and limits
    // ------------------------------------------------------------------
    localparam int QUEUE_DEPTH = 20;
    localparam int PTR_W = 5;
    localparam int CODE_W = 16;
    localparam int LEN_W = 7;
    localparam logic [PTR_W-1:0] PTR_LAST = 5'h13;
    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
    localparam logic [PTR_W-1:0] COUNT_FULL = 5'h14;
    localparam logic [PTR_W-1:0] COUNT_RESET = 5'h00;
    localparam logic [LEN_W-1:0] TEXT_MAX = 7'h50;
    localparam logic [7:0] HEADER_MAX = 8'h0C;
    localparam logic [15:0] EXP_MAX = 16'h7D00;
    localparam logic [9:0] DIGIT_MAX = 10'h0FF;
    localparam logic [7:0] STRING_MAX = 8'h28;

    typedef logic signed [CODE_W-1:0] code_t;
    typedef logic [LEN_W-1:0] len_t;

    // ------------------------------------------------------------------
    // Error codes, two's complement
    // ------------------------------------------------------------------
    localparam code_t CODE_NO_ERROR = 16'sh0000;
    localparam code_t CODE_HEADER_LONG = 16'shFF90;
    localparam code_t CODE_NUM_OVERFLOW = 16'shFF85;
    localparam code_t CODE_TOO_MANY_DIGITS = 16'shFF84;
    localparam code_t CODE_BLOCK_DATA = 16'shFF60;
    localparam code_t CODE_EXPRESSION = 16'shFF56;
    localparam code_t CODE_TRIG_IGNORED = 16'shFF2D;
    localparam code_t CODE_OUT_OF_RANGE = 16'shFF22;
    localparam code_t CODE_TOO_MUCH_DATA = 16'shFF21;
    localparam code_t CODE_SELF_TEST = 16'shFEB6;
    localparam code_t CODE_QUEUE_OVERFLOW = 16'shFEA2;
    localparam code_t CODE_INTERRUPTED = 16'shFE66;
    localparam code_t CODE_UNTERMINATED = 16'shFE5C;
    localparam code_t CODE_DEADLOCKED = 16'shFE52;
    localparam code_t CODE_INDEFINITE = 16'shFE48;

    // Length of the quoted description that goes with a built-in code.
    function automatic len_t textLen(input code_t code);
        case (code)
            CODE_NO_ERROR: textLen = 7'h08;
            CODE_HEADER_LONG: textLen = 7'h19;
            CODE_NUM_OVERFLOW: textLen = 7'h10;
            CODE_TOO_MANY_DIGITS: textLen = 7'h0F;
            CODE_TRIG_IGNORED: textLen = 7'h0F;
            CODE_OUT_OF_RANGE: textLen = 7'h11;
            CODE_TOO_MUCH_DATA: textLen = 7'h0D;
            CODE_QUEUE_OVERFLOW: textLen = 7'h0E;
            CODE_INTERRUPTED: textLen = 7'h11;
            CODE_UNTERMINATED: textLen = 7'h12;
            CODE_INDEFINITE: textLen = 7'h2C;
            default: textLen = 7'h10;
        endcase
    endfunction

endpackage

// ---- design/error_source_select.sv ----
`timescale 1ns/10ps
module error_source_select
    import error_event_queue_pkg::*;
(
    // Pending second self-test code
    input wire logic stPending,
    input wire error_event_queue_pkg::code_t stCode,
    input wire logic selfTestFail,
    // Response buffer events
    input wire logic respInterrupted,
    input wire logic respUnterminated,
    input wire logic deadlock,
    input wire logic idnNotLast,
    // Parser checks
    input wire logic headerDone,
    input wire logic [7:0] headerLen,
    input wire logic numDone,
    input wire logic [15:0] expMag,
    input wire logic [9:0] mantDigits,
    input wire logic [9:0] mantLeadZeros,
    input wire logic strDone,
    input wire logic [7:0] strLen,
    input wire logic blockData,
    input wire logic exprData,
    input wire logic rangeErr,
    // Trigger
    input wire logic busTrigger,
    input wire logic trigSourceBus,
    input wire logic trigInitiated,
    // Generic producer
    input wire logic errPush,
    input wire error_event_queue_pkg::code_t errCode,
    input wire error_event_queue_pkg::len_t errLen,
    // Selected error
    output logic hit,
    output error_event_queue_pkg::code_t code,
    output error_event_queue_pkg::len_t len,
    output logic reject
);
    logic [9:0] sigDigits;

    // Leading zeros do not count toward the mantissa length.
    assign sigDigits = (mantDigits > mantLeadZeros) ?
        mantDigits - mantLeadZeros : 10'h000;

    // One error per cycle; a fixed priority picks it and the rest are lost.
    always_comb begin
        hit = 1'b1;
        code = CODE_NO_ERROR;
        reject = 1'b0;
        if (stPending) begin
            code = stCode;
        end else if (selfTestFail) begin
            code = CODE_SELF_TEST;
        end else if (deadlock) begin
            code = CODE_DEADLOCKED;
        end else if (respInterrupted) begin
            code = CODE_INTERRUPTED;
        end else if (respUnterminated) begin
            code = CODE_UNTERMINATED;
        end else if (idnNotLast) begin
            code = CODE_INDEFINITE;
        end else if (headerDone && headerLen > HEADER_MAX) begin
            code = CODE_HEADER_LONG;
        end else if (numDone && expMag > EXP_MAX) begin
            code = CODE_NUM_OVERFLOW;
        end else if (numDone && sigDigits > DIGIT_MAX) begin
            code = CODE_TOO_MANY_DIGITS;
        end else if (strDone && strLen > STRING_MAX) begin
            code = CODE_TOO_MUCH_DATA;
            reject = 1'b1;
        end else if (blockData) begin
            code = CODE_BLOCK_DATA;
            reject = 1'b1;
        end else if (exprData) begin
            code = CODE_EXPRESSION;
            reject = 1'b1;
        end else if (busTrigger && !(trigSourceBus && trigInitiated)) begin
            code = CODE_TRIG_IGNORED;
        end else if (rangeErr) begin
            code = CODE_OUT_OF_RANGE;
        end else if (errPush) begin
            code = errCode;
        end else begin
            hit = 1'b0;
        end
    end

    // Producer text is clamped so a description never exceeds the limit.
    always_comb begin
        if (!stPending && !selfTestFail && errPush && code == errCode) begin
            len = (errLen > TEXT_MAX) ? TEXT_MAX : errLen;
        end else begin
            len = textLen(code);
        end
    end
endmodule

// ---- verif/error_host_model.sv ----
`timescale 1ns/10ps
// Remote host: sends one error query at a time and collects the answer.
module error_host_model
    import error_event_queue_pkg::*;
(
    // Clock
    input wire logic clock,
    // Answer from the queue
    input wire logic readValid,
    input wire error_event_queue_pkg::code_t readCode,
    input wire error_event_queue_pkg::len_t readLen,
    // Query strobe
    output logic errorRead
);
    initial errorRead = 1'b0;

    // The query stands for one cycle only, so one entry is asked for.
    // The answer is taken at the falling edge after its fixed latency.
    task automatic fetch(output logic v, output code_t c, output len_t l);
        @(negedge clock);
        errorRead = 1'b1;
        @(negedge clock);
        errorRead = 1'b0;
        v = readValid;
        c = readCode;
        l = readLen;
    endtask
endmodule

// ---- verif/error_event_queue_tb.sv ----
`timescale 1ns/10ps
module error_event_queue_tb;
    import error_event_queue_pkg::*;
    // Strobes: respCmd, talk, resetCmd, clear, header, number, string,
    // block, expr, range, trigger, respOverflow, selfTestFail (bit 0 up).
    logic [12:0] pulses;
    logic clock, nrst, errPush, errorRead, inputFull, idnNotLast;
    logic trigSourceBus, trigInitiated, readValid, errorLamp, beep;
    logic responsePending, cmdRejected;
    code_t errCode, selfTestCode, readCode;
    len_t errLen, readLen;
    logic [7:0] headerLen, strLen;
    logic [15:0] expMag;
    logic [9:0] mantDigits, mantLeadZeros;
    int n_mismatch = 0;
    int samples_checked = 0;

    error_event_queue uut (.clock, .nrst, .errPush, .errCode, .errLen,
        .errorRead, .clearStatus(pulses[3]), .resetCmd(pulses[2]),
        .headerDone(pulses[4]), .headerLen, .numDone(pulses[5]), .expMag,
        .mantDigits, .mantLeadZeros, .strDone(pulses[6]), .strLen,
        .blockData(pulses[7]), .exprData(pulses[8]), .rangeErr(pulses[9]),
        .busTrigger(pulses[10]), .trigSourceBus, .trigInitiated,
        .respCmd(pulses[0]), .talkAddressed(pulses[1]),
        .respOverflow(pulses[11]), .inputFull, .idnNotLast,
        .selfTestFail(pulses[12]), .selfTestCode, .readValid, .readCode,
        .readLen, .errorLamp, .beep, .responsePending, .cmdRejected);
    error_host_model host (.clock, .readValid, .readCode, .readLen,
        .errorRead);

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One query through the host; compares the whole returned entry.
    task automatic head(input code_t c, input len_t l);
        logic v;
        code_t rc;
        len_t rl;
        host.fetch(v, rc, rl);
        check("readValid", v, 1'b1);
        check("readCode", rc, c);
        check("readLen", rl, l);
    endtask

    task automatic pulse(input int k);
        @(negedge clock);
        pulses[k] = 1'b1;
        @(negedge clock);
        pulses[k] = 1'b0;
    endtask

    task automatic push(input code_t c);
        @(negedge clock);
        errPush = 1'b1;
        errCode = c;
        errLen = 7'h05;
        @(negedge clock);
        errPush = 1'b0;
        check("beep", beep, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_fifo;
        logic v;
        code_t rc;
        len_t rl;
        check("errorLamp", errorLamp, 1'b0);
        head(CODE_NO_ERROR, 7'h08);
        push(16'sh0101);
        check("errorLamp", errorLamp, 1'b1);
        @(negedge clock);
        check("beep", beep, 1'b0);
        push(16'sh0102);
        push(16'sh0103);
        head(16'sh0101, 7'h05);
        head(16'sh0102, 7'h05);
        check("errorLamp", errorLamp, 1'b1);
        head(16'sh0103, 7'h05);
        check("errorLamp", errorLamp, 1'b0);
        // Store into the empty queue, then query on the very next cycle.
        fork
            push(16'sh0104);
            begin
                @(negedge clock);
                host.fetch(v, rc, rl);
            end
        join
        check("readCode", rc, 16'sh0104);
    endtask

    task automatic sc_overflow;
        for (int i = 0; i < 22; i++) push(16'sh0200 + 16'(i));
        for (int i = 0; i < 19; i++) begin
            head(16'sh0200 + 16'(i), 7'h05);
        end
        head(CODE_QUEUE_OVERFLOW, 7'h0E);
        head(CODE_NO_ERROR, 7'h08);
    endtask

    // A query and a push in one cycle on a full queue keep the push.
    task automatic sc_both;
        logic v;
        code_t rc;
        len_t rl;
        for (int i = 0; i < 20; i++) push(16'sh0600 + 16'(i));
        fork
            host.fetch(v, rc, rl);
            push(16'sh0700);
        join
        check("readCode", rc, 16'sh0600);
        for (int i = 1; i < 20; i++) begin
            head(16'sh0600 + 16'(i), 7'h05);
        end
        head(16'sh0700, 7'h05);
    endtask

    task automatic sc_sources;
        int src[6] = '{4, 7, 8, 9, 10, 1};
        code_t ec[6] = '{CODE_HEADER_LONG, CODE_BLOCK_DATA, CODE_EXPRESSION,
            CODE_OUT_OF_RANGE, CODE_TRIG_IGNORED, CODE_UNTERMINATED};
        len_t el[6] = '{7'h19, 7'h10, 7'h10, 7'h11, 7'h0F, 7'h12};
        headerLen = 8'h0C;
        pulse(4);
        head(CODE_NO_ERROR, 7'h08);
        headerLen = 8'h0D;
        for (int k = 0; k < 6; k++) begin
            pulse(src[k]);
            head(ec[k], el[k]);
        end
        // A bus trigger with the bus source armed is accepted silently.
        {trigSourceBus, trigInitiated} = 2'b11;
        pulse(10);
        head(CODE_NO_ERROR, 7'h08);
        expMag = 16'h7D01;
        pulse(5);
        head(CODE_NUM_OVERFLOW, 7'h10);
        expMag = 16'h7D00;
        mantDigits = 10'h105;
        mantLeadZeros = 10'h006;
        pulse(5);
        head(CODE_NO_ERROR, 7'h08);
        mantLeadZeros = 10'h005;
        pulse(5);
        head(CODE_TOO_MANY_DIGITS, 7'h0F);
        strLen = 8'h28;
        pulse(6);
        check("cmdRejected", cmdRejected, 1'b0);
        strLen = 8'h29;
        pulse(6);
        check("cmdRejected", cmdRejected, 1'b1);
        head(CODE_TOO_MUCH_DATA, 7'h0D);
        selfTestCode = 16'sh0259;
        pulse(12);
        head(CODE_SELF_TEST, 7'h10);
        head(16'sh0259, 7'h10);
    endtask

    task automatic sc_reply;
        pulse(0);
        check("responsePending", responsePending, 1'b1);
        pulse(0);
        check("responsePending", responsePending, 1'b1);
        head(CODE_INTERRUPTED, 7'h11);
        push(16'sh0501);
        pulse(2);
        check("responsePending", responsePending, 1'b0);
        head(16'sh0501, 7'h05);
        inputFull = 1'b1;
        pulse(11);
        inputFull = 1'b0;
        pulse(3);
        check("errorLamp", errorLamp, 1'b0);
        head(CODE_NO_ERROR, 7'h08);
        pulse(11);
        head(CODE_NO_ERROR, 7'h08);
        // A misplaced identification query is still logged by the device.
        idnNotLast = 1'b1;
        @(negedge clock);
        idnNotLast = 1'b0;
        head(CODE_INDEFINITE, 7'h2C);
    endtask

    // Bounded run: a hang counts as a mismatch and ends in the report.
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    // All inputs start idle; the misplaced-query flag is raised only
    // once, on purpose, near the end of the run.
    initial begin
        nrst = 1'b0;
        {pulses, errPush, errCode, errLen, inputFull, idnNotLast} = '0;
        {trigSourceBus, trigInitiated, selfTestCode, headerLen} = '0;
        {strLen, expMag, mantDigits, mantLeadZeros} = '0;
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        sc_fifo();
        sc_overflow();
        sc_both();
        sc_sources();
        sc_reply();
        print_verdict();
    end
endmodule
